// File: core/sec_pkg.sv
// shared constants and types of the serial eeprom core
package sec_pkg;

  // instruction codes seen in the first byte of a frame
  localparam logic [7:0] OP_ARM    = 8'h06;  // latch_arm_cmd
  localparam logic [7:0] OP_DISARM = 8'h04;  // latch_disarm_cmd
  localparam logic [7:0] OP_SREAD  = 8'h05;  // status_read_cmd
  localparam logic [7:0] OP_SWRITE = 8'h01;  // status_write_cmd
  localparam logic [7:0] OP_READ   = 8'h03;  // array read
  localparam logic [7:0] OP_WRITE  = 8'h02;  // array write
  localparam logic [7:0] OP_NONE   = 8'h00;  // never decoded, marks an ignored frame

  // array geometry
  localparam int ADDR_W     = 12;
  localparam int MEM_DEPTH  = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int COL_W      = 5;
  localparam int PAGE_W     = 7;

  // block guard codes and the first protected address of the quarter and half codes
  localparam logic [1:0]  BG_QUARTER   = 2'h1;
  localparam logic [1:0]  BG_HALF      = 2'h2;
  localparam logic [1:0]  BG_FULL      = 2'h3;
  localparam logic [11:0] QUARTER_BASE = 12'hc00;
  localparam logic [11:0] HALF_BASE    = 12'h800;

  // field positions inside a status-write data byte
  localparam int SR_PGE_BIT = 7;
  localparam int SR_BGH_BIT = 3;
  localparam int SR_BGL_BIT = 2;

  // bit position inside a byte
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // self-timed write cycle
  localparam int WRITE_TIME_NS = 5000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WC_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int WC_W          = 20;

  // byte phase of a frame
  typedef enum logic [1:0] {
    PH_OPCODE  = 2'b00,
    PH_ADDR_HI = 2'b01,
    PH_ADDR_LO = 2'b10,
    PH_DATA    = 2'b11
  } sec_phase_type;

  // write engine states
  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_BUSY = 1'b1
  } sec_wstate_type;

  // status_and_protection register, msb first
  typedef struct packed {
    logic       pin_guard_enable;
    logic [2:0] zero;
    logic       block_guard_hi;
    logic       block_guard_lo;
    logic       write_latch_bit;
    logic       busy;
  } sec_status_type;

  localparam sec_status_type STATUS_RESET = '0;

  // what the link side leaves behind when a frame ends
  typedef struct packed {
    logic [7:0]    opcode;
    sec_phase_type phase;
    logic [2:0]    bitpos;
    logic [6:0]    page;
    logic [7:0]    sr_data;
    logic          data_seen;
  } sec_frame_type;

endpackage : sec_pkg

// File: core/sec_core.sv
// serial eeprom command core: link shifter, status register, write engine, array
`timescale 1ns/10ps

module sec_core #(
  parameter int WC_CYCLES = sec_pkg::WC_CYCLES_DEF  // write cycle length in clk_sys cycles
) (
  input  wire logic clk_sys,   // system clock, 200 MHz
  input  wire logic sys_rst,   // synchronous reset, active high
  input  wire logic sck,       // serial clock from the host
  input  wire logic cs_n,      // chip select, active low
  input  wire logic si,        // serial data in
  input  wire logic hold_n,    // pause request, active low
  input  wire logic wp_n,      // write guard pin, active low
  output logic      so_o,      // serial data out
  output logic      so_oe      // serial data out enable
);

  // load value of the write cycle down counter
  localparam logic [sec_pkg::WC_W-1:0] WC_LOAD = sec_pkg::WC_W'(WC_CYCLES - 1);

  // ---------------- link side, clocked by sck ----------------

  sec_pkg::sec_phase_type phase_q;             // which byte of the frame
  logic [2:0]             bitpos_q;            // bit inside the byte
  logic [7:0]             shift_q;             // incoming bits
  logic [7:0]             opcode_q;            // accepted instruction
  logic [15:0]            addr_q;              // address as shifted in
  logic [4:0]             col_q;               // page buffer column
  logic [11:0]            rd_addr_q;           // read pointer, also page of a write
  logic                   rd_mode_q;           // array bytes go out
  logic                   st_mode_q;           // status bytes go out
  logic [7:0]             sr_data_q;           // status-write data byte
  logic [7:0]             page_buf_q [sec_pkg::PAGE_BYTES];  // loaded page bytes
  logic [sec_pkg::PAGE_BYTES-1:0] page_mask_q; // columns loaded this frame
  sec_pkg::sec_status_type st_meta_q;          // status crossing, first stage
  sec_pkg::sec_status_type st_link_q;          // status crossing, second stage
  logic [7:0]             rx_byte;             // byte completed at this edge
  logic                   byte_end;            // last bit of a byte
  logic                   hold_act;            // pause in force
  logic                   so_clr;              // output tri-state request

  // ---------------- system side, clocked by clk_sys except the select-rise frame copies ----------------

  logic                    cs_meta_q;          // select sync, first stage
  logic                    cs_sync_q;          // select sync, second stage
  logic                    cs_prev_q;          // select one cycle back
  logic                    wp_meta_q;          // guard pin sync, first stage
  logic                    wp_sync_q;          // guard pin sync, second stage
  logic                    wp_seen_q;          // guard pin was low in this frame
  sec_pkg::sec_status_type status_q;           // status_and_protection
  sec_pkg::sec_wstate_type wstate_q;           // write engine state
  logic [sec_pkg::WC_W-1:0] wc_cnt_q;          // write cycle down counter
  logic [7:0]              mem_q [sec_pkg::MEM_DEPTH];  // the array, never reset
  sec_pkg::sec_frame_type  frame;              // frame leftovers seen at select rise
  sec_pkg::sec_frame_type  frame_q;            // frame leftovers caught at select rise
  logic [sec_pkg::PAGE_BYTES-1:0] mask_keep_q; // loaded columns caught at select rise
  logic                    cs_rise;            // frame just ended
  logic                    cs_fall;            // frame just began
  logic                    hw_guard;           // hardware protection in force
  logic                    exact_one;          // frame was exactly one byte
  logic                    exact_two;          // frame was exactly two bytes
  logic                    data_whole;         // frame ended on a data byte boundary
  logic                    arm_go;             // set the latch
  logic                    disarm_go;          // clear the latch
  logic                    sw_go;              // start a status write
  logic                    aw_go;              // start an array write
  logic                    wc_done;            // last cycle of the write cycle

  // true when an address lies in the range the guard code protects
  function automatic logic guard_hit(input logic [1:0] code, input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (code == sec_pkg::BG_FULL) begin
      hit = 1'b1;
    end else if (code == sec_pkg::BG_HALF) begin
      hit = (a >= sec_pkg::HALF_BASE);
    end else if (code == sec_pkg::BG_QUARTER) begin
      hit = (a >= sec_pkg::QUARTER_BASE);
    end
    return hit;
  endfunction : guard_hit

  assign rx_byte  = {shift_q[6:0], si};
  assign byte_end = (bitpos_q == sec_pkg::BIT_LAST);
  // hold only pauses a selected device; sck is low across both hold edges
  assign hold_act = ~hold_n & ~cs_n;
  assign so_clr   = cs_n | hold_act | sys_rst;

  // bit and byte counting; select high clears the frame at once
  // input sampled on rising edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bitpos_q <= sec_pkg::BIT_FIRST;
      phase_q  <= sec_pkg::PH_OPCODE;
      shift_q  <= '0;
    end else if (!hold_act) begin
      bitpos_q <= bitpos_q + 3'h1;
      shift_q  <= rx_byte;
      if (byte_end && phase_q != sec_pkg::PH_DATA) begin
        phase_q <= sec_pkg::sec_phase_type'(phase_q + 2'h1);
      end
    end
  end

  // instruction capture at the eighth bit
  // first byte is the instruction
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      opcode_q  <= sec_pkg::OP_NONE;
      st_mode_q <= 1'b0;
    end else if (!hold_act && phase_q == sec_pkg::PH_OPCODE && byte_end) begin
      if (st_link_q.busy && rx_byte != sec_pkg::OP_SREAD) begin
        opcode_q <= sec_pkg::OP_NONE;
      end else begin
        opcode_q <= rx_byte;
      end
      st_mode_q <= (rx_byte == sec_pkg::OP_SREAD);
    end
  end

  // address shift, read pointer and write column
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      addr_q    <= '0;
      rd_addr_q <= '0;
      col_q     <= '0;
      rd_mode_q <= 1'b0;
    end else if (!hold_act) begin
      if (phase_q == sec_pkg::PH_ADDR_HI || phase_q == sec_pkg::PH_ADDR_LO) begin
        addr_q <= {addr_q[14:0], si};
      end
      if (phase_q == sec_pkg::PH_ADDR_LO && byte_end) begin
        rd_addr_q <= {addr_q[10:0], si};
        col_q     <= {addr_q[3:0], si};
        rd_mode_q <= (opcode_q == sec_pkg::OP_READ);
      end else if (phase_q == sec_pkg::PH_DATA && byte_end) begin
        if (rd_mode_q) begin
          rd_addr_q <= rd_addr_q + 12'h1;
        end
        col_q <= col_q + 5'h1;
      end
    end
  end

  // status-write data byte and the loaded-column mask
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      sr_data_q   <= '0;
      page_mask_q <= '0;
    end else if (!hold_act && byte_end) begin
      // the one data byte follows the instruction
      if (phase_q == sec_pkg::PH_ADDR_HI && opcode_q == sec_pkg::OP_SWRITE) begin
        sr_data_q <= rx_byte;
      end
      if (phase_q == sec_pkg::PH_DATA && opcode_q == sec_pkg::OP_WRITE) begin
        page_mask_q[col_q] <= 1'b1;
      end
    end
  end

  // page buffer; a wrapped column overwrites the earlier byte
  // page loading
  always_ff @(posedge sck) begin
    if (!cs_n && !hold_act && byte_end && phase_q == sec_pkg::PH_DATA && opcode_q == sec_pkg::OP_WRITE) begin
      page_buf_q[col_q] <= rx_byte;
    end
  end

  // status into the link domain; sck runs only in frames, so the copy is
  // refreshed by the first edges of a frame, well before bit eight
  always_ff @(posedge sck) begin
    st_meta_q <= status_q;
    st_link_q <= st_meta_q;
  end

  // serial output; the array is read across domains, which is safe because
  // it only changes at a frame end and reads are refused while busy
  // output changes on falling edge
  always_ff @(negedge sck or posedge so_clr) begin
    if (so_clr) begin
      // hold or deselect floats the output
      so_oe <= 1'b0;
      so_o  <= 1'b0;
    end else if (rd_mode_q) begin
      so_oe <= 1'b1;
      so_o  <= mem_q[rd_addr_q][~bitpos_q];
    end else if (st_mode_q) begin
      so_oe <= 1'b1;
      so_o  <= st_link_q[~bitpos_q];
    end else begin
      so_oe <= 1'b0;
      so_o  <= 1'b0;
    end
  end

  // ---------------- system domain ----------------

  // pin synchronisers; select idles high so reset loads ones
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      wp_meta_q <= wp_n;
      wp_sync_q <= wp_meta_q;
    end
  end

  assign cs_rise = cs_sync_q & ~cs_prev_q;
  assign cs_fall = ~cs_sync_q & cs_prev_q;

  // remember a guard pin low at any time while selected
  // pin falling inside the frame blocks the status write at its end when pin_guard_enable is set
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_seen_q <= 1'b0;
    end else if (cs_fall) begin
      wp_seen_q <= ~wp_sync_q;
    end else if (!cs_sync_q && !wp_sync_q) begin
      wp_seen_q <= 1'b1;
    end
  end

  // frame leftovers caught on the rising select edge itself; that same edge
  // clears the link registers, so a later copy would only see reset values.
  // the copies stand still until the next frame ends, long after the
  // synchronised select edge has been acted on
  always_ff @(posedge cs_n) begin
    frame_q     <= '{opcode:    opcode_q,
                     phase:     phase_q,
                     bitpos:    bitpos_q,
                     page:      rd_addr_q[11:5],
                     sr_data:   sr_data_q,
                     data_seen: |page_mask_q};
    mask_keep_q <= page_mask_q;
  end

  assign frame = frame_q;

  // command decisions at the end of a frame
  always_comb begin
    hw_guard   = status_q.pin_guard_enable & (wp_seen_q | ~wp_sync_q);
    exact_one  = (frame.phase == sec_pkg::PH_ADDR_HI) && (frame.bitpos == sec_pkg::BIT_FIRST);
    exact_two  = (frame.phase == sec_pkg::PH_ADDR_LO) && (frame.bitpos == sec_pkg::BIT_FIRST);
    data_whole = (frame.phase == sec_pkg::PH_DATA) && (frame.bitpos == sec_pkg::BIT_FIRST) && frame.data_seen;
    // latch commands, frame of one byte
    // arm counts only if select rises after bit eight
    arm_go    = cs_rise && wstate_q == sec_pkg::WS_IDLE && frame.opcode == sec_pkg::OP_ARM && exact_one;
    disarm_go = cs_rise && wstate_q == sec_pkg::WS_IDLE && frame.opcode == sec_pkg::OP_DISARM && exact_one;
    // latch and pin guard gate status write
    // without prior arm the latch is clear
    sw_go = cs_rise && wstate_q == sec_pkg::WS_IDLE && frame.opcode == sec_pkg::OP_SWRITE && exact_two
            && status_q.write_latch_bit && !hw_guard;
    aw_go = cs_rise && wstate_q == sec_pkg::WS_IDLE && frame.opcode == sec_pkg::OP_WRITE && data_whole
            && status_q.write_latch_bit
            && !guard_hit({status_q.block_guard_hi, status_q.block_guard_lo}, {frame.page, 5'h00});
  end

  assign wc_done = (wstate_q == sec_pkg::WS_BUSY) && (wc_cnt_q == '0);

  // write engine: self-timed cycle after an accepted write frame
  // start only at select rising
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wstate_q <= sec_pkg::WS_IDLE;
      wc_cnt_q <= '0;
    end else begin
      case (wstate_q)
        sec_pkg::WS_IDLE: begin
          if (sw_go || aw_go) begin
            wstate_q <= sec_pkg::WS_BUSY;
            wc_cnt_q <= WC_LOAD;
          end
        end
        sec_pkg::WS_BUSY: begin
          if (wc_done) begin
            wstate_q <= sec_pkg::WS_IDLE;
          end else begin
            wc_cnt_q <= wc_cnt_q - 1'b1;
          end
        end
        default: begin
          wstate_q <= sec_pkg::WS_IDLE;
        end
      endcase
    end
  end

  // status register; guard bits model non-volatile storage but still take a
  // defined value on reset so simulation starts clean
  // fixed layout, bits 6..4 stay zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_q <= sec_pkg::STATUS_RESET;
    end else begin
      status_q.busy <= sw_go | aw_go | ((wstate_q == sec_pkg::WS_BUSY) && !wc_done);
      // end of write cycle clears the latch
      if (arm_go) begin
        status_q.write_latch_bit <= 1'b1;
      end else if (disarm_go || wc_done) begin
        status_q.write_latch_bit <= 1'b0;
      end
      // guard bits loaded by status write
      // only bits 7, 3, 2 change
      if (sw_go) begin
        status_q.pin_guard_enable <= frame.sr_data[sec_pkg::SR_PGE_BIT];
        status_q.block_guard_hi   <= frame.sr_data[sec_pkg::SR_BGH_BIT];
        status_q.block_guard_lo   <= frame.sr_data[sec_pkg::SR_BGL_BIT];
      end
    end
  end

  // array programming: loaded columns are copied at the start of the cycle,
  // while the link is idle, so the buffer needs no second copy
  // only loaded columns are programmed
  always_ff @(posedge clk_sys) begin
    if (aw_go) begin
      for (int i = 0; i < sec_pkg::PAGE_BYTES; i++) begin
        if (mask_keep_q[i]) begin
          mem_q[{frame.page, i[4:0]}] <= page_buf_q[i];
        end
      end
    end
  end

endmodule : sec_core

// File: verif/sec_core_properties.sv
// checker watching the serial pins of the eeprom core
`timescale 1ns/10ps
module sec_core_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic        sck_q;      // sck one clk_sys earlier
  logic [15:0] bit_cnt_q;  // input bits taken in this frame
  logic [7:0]  op_q;       // first byte of the frame
  logic        sck_rise;   // rising sck seen this cycle

  assign sck_rise = sck & ~sck_q;

  // count bits while selected and not paused; 15 ns sck leaves every phase sampled
  always_ff @(posedge clk_sys) begin
    sck_q <= sck;
    if (cs_n) begin
      bit_cnt_q <= 16'h0;
      op_q      <= 8'h00;
    end else if (sck_rise && hold_n) begin
      bit_cnt_q <= bit_cnt_q + 16'h1;
      if (bit_cnt_q < 16'h8) op_q <= {op_q[6:0], si};
    end
  end

  idle_float_a: assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  hold_float_a: assert property (!hold_n |-> !so_oe)
    else $error("output driven during pause");
  so_falling_a: assert property ((sck && sck_q && !cs_n && $past(!cs_n)) |-> $stable(so_o))
    else $error("data out moved while clock high");
  oe_falling_a: assert property ($rose(so_oe) |-> !sck)
    else $error("output enabled off the falling clock");
  opcode_gate_a: assert property ($rose(so_oe) |-> (op_q == sec_pkg::OP_SREAD || op_q == sec_pkg::OP_READ))
    else $error("output answered an opcode with no output");
  status_late_a: assert property (($rose(so_oe) && op_q == sec_pkg::OP_SREAD) |-> bit_cnt_q >= 16'h8)
    else $error("status driven before the eighth bit");
  read_late_a: assert property (($rose(so_oe) && op_q == sec_pkg::OP_READ) |-> bit_cnt_q >= 16'h18)
    else $error("read data driven before the address ended");
  status_prompt_a: assert property (($rose(bit_cnt_q == 16'h8) && op_q == sec_pkg::OP_SREAD)
    |-> ##[1:4] (so_oe || cs_n || !hold_n))
    else $error("status not driven after its command");

  cover property ($rose(so_oe) && op_q == sec_pkg::OP_SREAD);
  cover property ($rose(so_oe) && op_q == sec_pkg::OP_READ);
  cover property (!hold_n && !cs_n);
endmodule : sec_core_properties

bind sec_core sec_core_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
  .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));

// File: verif/sec_spi_host.sv
// host model driving select, clock and data of the serial link
`timescale 1ns/10ps
module sec_spi_host (
  output logic     sck,
  output logic     cs_n,
  output logic     si,
  output logic     hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  logic [7:0] tx [0:63];  // bytes sent, msb first
  logic [7:0] rx [0:63];  // bytes seen on the data line
  logic       mode3;      // clock idles high when set
  logic       hold_oe;    // output enable seen while paused
  logic       so_line;    // line level; undriven reads back inverted

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    mode3 = 1'b0;
    hold_oe = 1'b0;
    so_line = 1'b0;
  end

  // one frame of n bytes; clock stands still outside it; pause before bit hold_at
  task automatic run_frame(input int n, input int hold_at);
    int i;
    sck = mode3;
    #7.5 cs_n = 1'b0;
    if (mode3) #7.5 sck = 1'b0;
    for (i = 0; i < 8 * n; i++) begin
      if (i == hold_at) begin
        hold_n = 1'b0;
        #30 hold_oe = so_oe;
        hold_n = 1'b1;
      end
      si = tx[i / 8][7 - i % 8];
      #7.5 sck = 1'b1;
      so_line = so_oe ? so_o : ~so_line;
      rx[i / 8][7 - i % 8] = so_line;
      #7.5 if (!mode3 || i < 8 * n - 1) sck = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    si = ~si;
    #30;
  endtask : run_frame
endmodule : sec_spi_host

// File: verif/sec_core_tb.sv
// self-checking bench for the serial eeprom core
`timescale 1ns/10ps
module sec_core_tb;
  localparam int WC = 300;  // shortened write cycle
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] st;
  } sec_row_type;

  logic       clk_sys, sys_rst, wp_n;
  logic       sck, cs_n, si, hold_n, so_o, so_oe;
  int         mismatches, check_count, k;
  logic [7:0] exp_pg [0:31];  // expected page zero
  // one-byte commands and the status they leave
  sec_row_type rows [0:5] = '{'{8'h06, 8'h02}, '{8'h04, 8'h00}, '{8'hff, 8'h00},
                              '{8'h06, 8'h02}, '{8'h07, 8'h02}, '{8'h04, 8'h00}};

  sec_core #(.WC_CYCLES(WC)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
  sec_spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic op1(input logic [7:0] op);
    host.tx[0] = op;
    host.run_frame(1, -1);
  endtask : op1

  task automatic stat(input logic [7:0] exp);
    host.tx[0] = sec_pkg::OP_SREAD;
    host.run_frame(2, -1);
    chk(host.rx[1], exp);
  endtask : stat

  task automatic status_write_cmd(input logic [7:0] v);
    host.tx[0] = sec_pkg::OP_SWRITE;
    host.tx[1] = v;
    host.run_frame(2, -1);
  endtask : status_write_cmd

  // opcode, full 16-bit address, n data bytes counting from d
  task automatic xfer(input logic [7:0] op, input logic [15:0] a, input int n, input logic [7:0] d);
    host.tx[0] = op;
    host.tx[1] = a[15:8];
    host.tx[2] = a[7:0];
    for (int j = 0; j < n; j++) host.tx[3 + j] = d + 8'(j);
    host.run_frame(3 + n, -1);
  endtask : xfer

  // the write cycle length is fixed by the parameter
  task automatic cyc;
    repeat (WC + 20) @(posedge clk_sys);
  endtask : cyc

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // cut a hang well past the expected run length
  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    mismatches = 0;
    check_count = 0;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    stat(8'h00);
    for (int i = 0; i < 6; i++) begin
      host.mode3 = i[0];
      op1(rows[i].op);
      stat(rows[i].st);
    end
    host.mode3 = 1'b0;
    op1(sec_pkg::OP_ARM);
    xfer(sec_pkg::OP_WRITE, 16'hf001, 33, 8'h40);
    stat(8'h03);
    op1(sec_pkg::OP_DISARM);
    stat(8'h03);
    cyc();
    stat(8'h00);
    op1(sec_pkg::OP_ARM);
    xfer(sec_pkg::OP_WRITE, 16'h0fff, 1, 8'h99);
    cyc();
    for (k = 0; k < 33; k++) exp_pg[(k + 1) % 32] = 8'h40 + 8'(k);
    xfer(sec_pkg::OP_READ, 16'h5fff, 33, 8'h00);
    chk(host.rx[3], 8'h99);
    for (k = 0; k < 32; k++) chk(host.rx[4 + k], exp_pg[k]);
    op1(sec_pkg::OP_ARM);
    status_write_cmd(8'hff);
    stat(8'h8f);
    cyc();
    stat(8'h8c);
    op1(sec_pkg::OP_ARM);
    xfer(sec_pkg::OP_WRITE, 16'h0001, 1, 8'h11);
    stat(8'h8e);
    // pin drops in mid-frame while guard enable is set
    host.tx[0] = sec_pkg::OP_SWRITE;
    host.tx[1] = 8'h00;
    fork
      host.run_frame(2, -1);
      begin
        #100;
        @(posedge clk_sys);
        #1 wp_n = 1'b0;
      end
    join
    cyc();
    stat(8'h8e);
    @(posedge clk_sys);
    #1 wp_n = 1'b1;
    status_write_cmd(8'h04);
    stat(8'h07);
    cyc();
    stat(8'h04);
    op1(sec_pkg::OP_ARM);
    xfer(sec_pkg::OP_WRITE, 16'h0c00, 1, 8'h22);
    stat(8'h06);
    xfer(sec_pkg::OP_WRITE, 16'h0bff, 1, 8'h33);
    stat(8'h07);
    cyc();
    xfer(sec_pkg::OP_READ, 16'h0bff, 1, 8'h00);
    chk(host.rx[3], 8'h33);
    xfer(sec_pkg::OP_READ, 16'h0001, 1, 8'h00);
    chk(host.rx[3], exp_pg[1]);
    // pause in the middle of a status stream
    host.mode3 = 1'b1;
    host.tx[0] = sec_pkg::OP_SREAD;
    host.run_frame(3, 12);
    chk({7'h00, host.hold_oe}, 8'h00);
    chk(host.rx[2], 8'h04);
    // second reset in mid-run drops an armed latch and the guard bits
    op1(sec_pkg::OP_ARM);
    stat(8'h06);
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    stat(8'h00);
    final_report();
  end
endmodule : sec_core_tb
